/* ssr_readback.sv */
// Top of the system signal status readback block.
// Assumes a host command parser drives the query ports; one clock.
//
// How it works
// - Answer is 0 for an inactive signal, 1 for an active one.
// - Continuous monitoring allowed only for immediate-mode queries, never from sequences.
// - Status is read-only; abort and start readable in immediate mode only.
// - Output signal internal states are reported even without a connector pin.
// - Status merges remote inputs and outputs with connector ones.
// - Each listed input signal has its own selector code and status.
// - Limit, jog and homing inputs report positive and negative separately.
`timescale 1ns/10ps
`default_nettype none
module ssr_readback (
	input wire logic i_clk_sys, // 10 MHz system clock
	input wire logic i_sys_rst, // Async reset, high
	input wire logic [ssr_pkg::NUM_IN-1:0] i_in_pin, // Connector input levels
	input wire logic [ssr_pkg::NUM_IN-1:0] i_in_remote, // Remote input levels
	input wire logic [ssr_pkg::NUM_OUT-1:0] i_out_state, // Internal output states
	input wire logic [ssr_pkg::NUM_OUT-1:0] i_out_remote, // Remote output levels
	input wire logic i_query_valid, // Query strobe, one cycle
	input wire logic [ssr_pkg::SEL_W-1:0] i_query_sel, // Signal selector
	input wire logic i_query_immediate, // 1 immediate mode, 0 sequence
	input wire logic i_query_monitor, // Request real-time monitor
	input wire logic i_monitor_stop, // End real-time monitor
	output logic o_ans_valid, // Answer strobe
	output logic o_ans_value, // Answer bit
	output logic o_ans_refused, // Query refused
	output logic o_monitor_active // Monitor running
);
	import ssr_pkg::*;
	// Snapshot and selected bit shared with the sampler
	ssr_snap_if snap_if ();
	typedef struct packed {
		ssr_state_t state;
		logic [SEL_W-1:0] sel;
		logic ans_valid;
		logic ans_value;
		logic ans_refused;
		logic monitor;
		logic last_val;
		logic fetch;
	} ssr_top_t;
	ssr_top_t st_ff;
	ssr_top_t nxt_st;
	logic [NUM_SIG-1:0] pin_all;
	logic [NUM_SIG-1:0] rem_all;
	logic sel_in;
	logic sel_dir;
	logic sel_out;
	logic sel_ok;
	logic immed_only;
	logic refuse_sel;
	logic refuse_mon;
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Selector must reach every signal, outputs last
	if (NUM_SIG > (1 << SEL_W)) begin : g_sel_narrow
		$error("Selector too narrow for signal count");
	end
	if (SEL_LAST != NUM_SIG - 1) begin : g_sel_last
		$error("Last selector must name the last signal");
	end
	if (SSR_SIG_OUT_BASE != NUM_IN) begin : g_out_base
		$error("Output codes must follow input codes");
	end
	// ----------------------------------------
	// Sampling
	// ----------------------------------------
	// Output states sit above the inputs in selector order
	assign pin_all = {i_out_state, i_in_pin};
	assign rem_all = {i_out_remote, i_in_remote};
	ssr_sampler #(
		.N(NUM_SIG)
	) u_sampler (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_pin(pin_all),
		.i_remote(rem_all),
		.snap_if(snap_if)
	);
	assign snap_if.sel = st_ff.sel;
	// ----------------------------------------
	// Selector decode
	// ----------------------------------------
	always_comb begin
		sel_in = 1'b0;
		sel_dir = 1'b0;
		sel_out = 1'b0;
		immed_only = 1'b0;
		// Every listed signal has a code of its own
		case (i_query_sel)
			SSR_SIG_ABORT,
			SSR_SIG_START: begin
				sel_in = 1'b1;
				immed_only = 1'b1;
			end
			SSR_SIG_ALARM_CLEAR,
			SSR_SIG_CURRENT_ON,
			SSR_SIG_CURRENT_FREE,
			SSR_SIG_HOME_SENSOR,
			SSR_SIG_CONTINUE,
			SSR_SIG_MOTOR_HALT,
			SSR_SIG_PAUSE,
			SSR_SIG_PAUSE_CLEAR,
			SSR_SIG_POS_ERR_CLEAR,
			SSR_SIG_PANIC_HALT,
			SSR_SIG_SENSOR,
			SSR_SIG_TORQUE_LIMIT: begin
				sel_in = 1'b1;
			end
			SSR_SIG_LIMIT_POS,
			SSR_SIG_LIMIT_NEG,
			SSR_SIG_JOG_POS,
			SSR_SIG_JOG_NEG,
			SSR_SIG_HOMING_POS,
			SSR_SIG_HOMING_NEG: begin
				sel_dir = 1'b1;
			end
			default: begin
				// Codes above the inputs up to the last name output states
				sel_out = (i_query_sel <= SEL_LAST);
			end
		endcase
		sel_ok = sel_in || sel_dir || sel_out;
	end
	// ----------------------------------------
	// Refusal rules
	// ----------------------------------------
	always_comb begin
		// Abort and start status stays hidden from sequences
		refuse_sel = !sel_ok || (immed_only && !i_query_immediate);
		// Real-time monitor only from immediate mode
		refuse_mon = i_query_monitor && !i_query_immediate;
	end
	// ----------------------------------------
	// Query engine
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ans_valid = 1'b0;
		nxt_st.ans_refused = 1'b0;
		case (st_ff.state)
			SSR_ST_IDLE: begin
				if (i_query_valid) begin
					// Refused queries answer at once with value zero
					if (refuse_sel) begin
						nxt_st.ans_refused = 1'b1;
						nxt_st.ans_valid = 1'b1;
						nxt_st.ans_value = ANS_INACTIVE;
					end else if (refuse_mon) begin
						nxt_st.ans_refused = 1'b1;
						nxt_st.ans_valid = 1'b1;
						nxt_st.ans_value = ANS_INACTIVE;
					end else begin
						nxt_st.sel = i_query_sel;
						nxt_st.monitor = i_query_monitor;
						nxt_st.state = SSR_ST_ANSWER;
						// Sampler needs one cycle to pick the new bit
						nxt_st.fetch = 1'b1;
					end
				end
			end
			SSR_ST_ANSWER: begin
				if (i_monitor_stop) begin
					nxt_st.monitor = 1'b0;
				end
				if (st_ff.fetch) begin
					// Sampler bit still shows the previous selector
					nxt_st.fetch = 1'b0;
				end else begin
					nxt_st.ans_valid = 1'b1;
					nxt_st.ans_value = snap_if.bit_val;
					nxt_st.last_val = snap_if.bit_val;
					nxt_st.state = nxt_st.monitor ? SSR_ST_MONITOR : SSR_ST_IDLE;
				end
			end
			SSR_ST_MONITOR: begin
				// Changes only; the first value was already sent
				if (i_monitor_stop) begin
					nxt_st.monitor = 1'b0;
					nxt_st.state = SSR_ST_IDLE;
				end else if (snap_if.bit_val != st_ff.last_val) begin
					nxt_st.ans_valid = 1'b1;
					nxt_st.ans_value = snap_if.bit_val;
					nxt_st.last_val = snap_if.bit_val;
				end
			end
			default: begin
				nxt_st.state = SSR_ST_IDLE;
				nxt_st.monitor = 1'b0;
				nxt_st.fetch = 1'b0;
			end
		endcase
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_ff.state <= SSR_ST_IDLE;
			st_ff.sel <= '0;
			st_ff.ans_valid <= 1'b0;
			st_ff.ans_value <= ANS_INACTIVE;
			st_ff.ans_refused <= 1'b0;
			st_ff.monitor <= 1'b0;
			st_ff.last_val <= 1'b0;
			st_ff.fetch <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// All straight from the state register
	assign o_ans_valid = st_ff.ans_valid;
	assign o_ans_value = st_ff.ans_value;
	assign o_ans_refused = st_ff.ans_refused;
	assign o_monitor_active = st_ff.monitor;
endmodule : ssr_readback
`default_nettype wire

/* ssr_pkg.sv */
// Package for the system signal status readback block.
// Assumes one controller clock; no register bus, all controls are ports.
package ssr_pkg;
	// ----------------------------------------
	// Signal selector codes
	// ----------------------------------------
	localparam int SEL_W = 5;
	typedef enum logic [SEL_W-1:0] {
		SSR_SIG_ABORT = 5'h00,
		SSR_SIG_ALARM_CLEAR = 5'h01,
		SSR_SIG_CURRENT_ON = 5'h02,
		SSR_SIG_CURRENT_FREE = 5'h03,
		SSR_SIG_HOME_SENSOR = 5'h04,
		SSR_SIG_CONTINUE = 5'h05,
		SSR_SIG_LIMIT_POS = 5'h06,
		SSR_SIG_LIMIT_NEG = 5'h07,
		SSR_SIG_JOG_POS = 5'h08,
		SSR_SIG_JOG_NEG = 5'h09,
		SSR_SIG_HOMING_POS = 5'h0A,
		SSR_SIG_HOMING_NEG = 5'h0B,
		SSR_SIG_MOTOR_HALT = 5'h0C,
		SSR_SIG_PAUSE = 5'h0D,
		SSR_SIG_PAUSE_CLEAR = 5'h0E,
		SSR_SIG_POS_ERR_CLEAR = 5'h0F,
		SSR_SIG_PANIC_HALT = 5'h10,
		SSR_SIG_SENSOR = 5'h11,
		SSR_SIG_START = 5'h12,
		SSR_SIG_TORQUE_LIMIT = 5'h13,
		SSR_SIG_OUT_BASE = 5'h14
	} ssr_sel_t;
	localparam int NUM_IN = 20;
	localparam int NUM_OUT = 9;
	localparam int NUM_SIG = NUM_IN + NUM_OUT;
	localparam logic [SEL_W-1:0] SEL_LAST = 5'h1C;
	// Answer values
	localparam logic ANS_INACTIVE = 1'h0;
	localparam logic ANS_ACTIVE = 1'h1;
	// ----------------------------------------
	// Query engine states
	// ----------------------------------------
	typedef enum logic [2:0] {
		SSR_ST_IDLE = 3'h1,
		SSR_ST_ANSWER = 3'h2,
		SSR_ST_MONITOR = 3'h4
	} ssr_state_t;
endpackage : ssr_pkg

/* ssr_snap_if.sv */
// Interface carrying the sampled signal snapshot between modules.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
`default_nettype none
interface ssr_snap_if;
	import ssr_pkg::*;
	logic [NUM_SIG-1:0] snap;
	logic [SEL_W-1:0] sel;
	logic bit_val;
	modport sampler (output snap, input sel, output bit_val);
	modport engine (input snap, output sel, input bit_val);
endinterface : ssr_snap_if
`default_nettype wire

/* ssr_sampler.sv */
// Snapshot sampler: merges connector and remote signals each clock.
// Assumes inputs are synchronous to i_clk_sys.
`timescale 1ns/10ps
`default_nettype none
module ssr_sampler #(
	parameter int N = ssr_pkg::NUM_SIG
) (
	input wire logic i_clk_sys, // System clock
	input wire logic i_sys_rst, // Async reset, high
	input wire logic [N-1:0] i_pin, // Connector levels, active high
	input wire logic [N-1:0] i_remote, // Remote levels, active high
	ssr_snap_if.sampler snap_if // Snapshot to engine
);
	import ssr_pkg::*;
	if (N != NUM_SIG) begin : g_bad_width
		$error("Sampler width must match signal count");
	end
	typedef struct packed {
		logic [N-1:0] snap;
		logic bit_val;
	} ssr_samp_t;
	ssr_samp_t st_ff;
	ssr_samp_t nxt_st;
	logic [N-1:0] merged;
	always_comb begin
		merged = i_pin | i_remote;
		nxt_st = st_ff;
		nxt_st.snap = merged;
		nxt_st.bit_val = (snap_if.sel <= SEL_LAST) ? st_ff.snap[snap_if.sel] : ANS_INACTIVE;
	end
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign snap_if.snap = st_ff.snap;
	assign snap_if.bit_val = st_ff.bit_val;
endmodule : ssr_sampler
`default_nettype wire

/* ssr_host.sv */
// Host model issuing status queries; drives at falling edges.
`timescale 1ns/10ps
`default_nettype none
module ssr_host (
	input wire logic i_clk_sys, // clock
	output logic o_valid, // strobe
	output logic [4:0] o_sel, // selector
	output logic o_imm, // mode
	output logic o_mon // monitor
);
	initial {o_valid, o_sel, o_imm, o_mon} = '0;
	task automatic ask(input logic [4:0] s, input logic im, mn);
		@(negedge i_clk_sys);
		{o_sel, o_imm, o_mon, o_valid} = {s, im, mn, 1'b1};
		@(negedge i_clk_sys);
		o_valid = 0;
	endtask : ask
endmodule : ssr_host
`default_nettype wire

/* ssr_readback_asserts.sv */
// Checker on the readback ports; assumes one query at a time.
`timescale 1ns/10ps
`default_nettype none
module ssr_readback_asserts (
	input wire logic i_clk_sys, // clk
	input wire logic i_sys_rst, // rst
	input wire logic [19:0] i_in_pin, // pins
	input wire logic [19:0] i_in_remote, // remote
	input wire logic i_query_valid, // query
	input wire logic [4:0] i_query_sel, // sel
	input wire logic i_query_immediate, // mode
	input wire logic i_query_monitor, // mon
	input wire logic i_monitor_stop, // stop
	input wire logic o_ans_valid, // ans
	input wire logic o_ans_value, // bit
	input wire logic o_ans_refused, // ref
	input wire logic o_monitor_active // mon on
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	wire logic q = i_query_valid && !o_monitor_active;
	wire logic im = i_query_immediate;
	wire logic [4:0] s = i_query_sel;
	wire logic [19:0] lv = i_in_pin | i_in_remote;
	in_value_a: assert property (q && im && s < 5'h14 && !i_query_monitor
		|-> ##3 o_ans_valid && !o_ans_refused && o_ans_value == lv[s]) else $error("value");
	seq_read_a: assert property (q && !im && s == 5'h01 && !i_query_monitor
		|-> ##3 o_ans_valid && !o_ans_refused) else $error("seq read");
	abort_seq_a: assert property (q && !im && s == 5'h00 |=> o_ans_refused)
		else $error("abort");
	start_seq_a: assert property (q && !im && s == 5'h12 |=> o_ans_refused)
		else $error("start");
	mon_seq_a: assert property (q && !im && i_query_monitor |=> !o_monitor_active)
		else $error("mon seq");
	mon_on_a: assert property (q && im && s < 5'h1D && i_query_monitor |=> o_monitor_active)
		else $error("mon on");
	mon_off_a: assert property (o_monitor_active && i_monitor_stop |-> ##[1:2] !o_monitor_active)
		else $error("mon off");
	refused_zero_a: assert property (o_ans_refused |-> o_ans_valid && !o_ans_value)
		else $error("refused");
endmodule : ssr_readback_asserts
bind ssr_readback ssr_readback_asserts chk (
	.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst),
	.i_in_pin(i_in_pin),
	.i_in_remote(i_in_remote),
	.i_query_valid(i_query_valid),
	.i_query_sel(i_query_sel),
	.i_query_immediate(i_query_immediate),
	.i_query_monitor(i_query_monitor),
	.i_monitor_stop(i_monitor_stop),
	.o_ans_valid(o_ans_valid),
	.o_ans_value(o_ans_value),
	.o_ans_refused(o_ans_refused),
	.o_monitor_active(o_monitor_active)
);
`default_nettype wire

/* ssr_readback_bench.sv */
// Bench for the readback block; assumes host model and bound checker.
`timescale 1ns/10ps
`default_nettype none
module ssr_readback_bench;
	logic i_clk_sys = 0, i_sys_rst = 1, i_monitor_stop = 0, ok;
	logic [19:0] i_in_pin = 20'h0F0F3, i_in_remote = 20'h30300;
	logic [8:0] i_out_state = 9'h0A5, i_out_remote = 9'h100;
	logic i_query_valid, i_query_immediate, i_query_monitor;
	logic [4:0] i_query_sel;
	logic o_ans_valid, o_ans_value, o_ans_refused, o_monitor_active;
	wire logic [28:0] all = {i_out_state | i_out_remote, i_in_pin | i_in_remote};
	int miscompares = 0, tests_run = 0;
	always #50 i_clk_sys = ~i_clk_sys;
	ssr_readback dut (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_in_pin(i_in_pin),
		.i_in_remote(i_in_remote),
		.i_out_state(i_out_state),
		.i_out_remote(i_out_remote),
		.i_query_valid(i_query_valid),
		.i_query_sel(i_query_sel),
		.i_query_immediate(i_query_immediate),
		.i_query_monitor(i_query_monitor),
		.i_monitor_stop(i_monitor_stop),
		.o_ans_valid(o_ans_valid),
		.o_ans_value(o_ans_value),
		.o_ans_refused(o_ans_refused),
		.o_monitor_active(o_monitor_active)
	);
	ssr_host host (.i_clk_sys, .o_valid(i_query_valid), .o_sel(i_query_sel),
		.o_imm(i_query_immediate), .o_mon(i_query_monitor));
	task automatic finish_test;
		if (miscompares == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : finish_test
	task automatic check(input string n, input logic e, g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %b seen %b", n, e, g);
		end
	endtask : check
	task automatic query(input logic [4:0] s, input logic i, m, er, ev, sd);
		if (sd) host.ask(s, i, m);
		// A refused answer already stands when the strobe drops
		ok = sd && (o_ans_valid === 1'b1);
		for (int n = 0; n < 8 && !ok; n++) begin
			@(negedge i_clk_sys);
			ok = o_ans_valid === 1'b1;
		end
		check("answer", 1, ok);
		if (!ok) finish_test();
		check("refused", er, o_ans_refused);
		check("value", ev, o_ans_value);
	endtask : query
	initial begin
		repeat (6) @(negedge i_clk_sys);
		i_sys_rst = 0;
		for (int k = 0; k < 29; k++) query(k[4:0], 1, 0, 0, all[k], 1);
		query(5'h00, 0, 0, 1, 0, 1);
		query(5'h12, 0, 0, 1, 0, 1);
		query(5'h01, 0, 0, 0, 1, 1);
		query(5'h1D, 1, 0, 1, 0, 1);
		query(5'h05, 0, 1, 1, 0, 1);
		query(5'h06, 1, 1, 0, 1, 1);
		check("monitor", 1, o_monitor_active);
		i_in_pin[6] = 0;
		query(5'h06, 1, 1, 0, 0, 0);
		i_monitor_stop = 1;
		@(negedge i_clk_sys);
		i_monitor_stop = 0;
		repeat (2) @(negedge i_clk_sys);
		check("monitor", 0, o_monitor_active);
		finish_test();
	end
endmodule : ssr_readback_bench
`default_nettype wire
